//--- inc/fdc_flow_pkg.sv
// constants and types shared by the floppy phase and fifo control block
package fdc_flow_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [4:0] ADR_DOR = 5'h00;
  localparam logic [4:0] ADR_RATE = 5'h04;
  localparam logic [4:0] ADR_ICFG = 5'h08;
  localparam logic [4:0] ADR_MSR = 5'h0c;
  localparam logic [4:0] ADR_DATA = 5'h10;
  localparam logic [4:0] ADR_ST3 = 5'h14;
  localparam logic [4:0] ADR_ST4 = 5'h18;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DOR_RST_BIT = 2;
  localparam int DOR_DMA_BIT = 3;
  localparam int DOR_HEAD_BIT = 4;
  localparam int RATE_RST_BIT = 7;
  localparam int RATE_PDOWN_BIT = 6;
  localparam int ICFG_BURST_BIT = 1;
  localparam int CFG_NOFIFO_BIT = 5;
  localparam int CFG_NOPOLL_BIT = 4;
  localparam int SPEC_NONDMA_BIT = 0;
  localparam int MSR_RQM_BIT = 7;
  localparam int MSR_DIO_BIT = 6;
  localparam int MSR_EXEC_BIT = 5;
  localparam int MSR_BUSY_BIT = 4;
  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [1:0] RATE_HIGH_DENS = 2'h0;
  localparam logic [1:0] IFM_COMPAT = 2'h0;
  localparam logic [1:0] IFM_ALWAYS = 2'h1;
  localparam logic [1:0] IFM_GATED = 2'h2;
  localparam logic [7:0] BAD_TRACK = 8'hff;
  localparam logic [7:0] RES_INVALID = 8'h80;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [3:0] N_SPECIFY = 4'h2;
  localparam logic [3:0] N_CONFIGURE = 4'h3;
  localparam logic [3:0] N_XFER = 4'h8;
  localparam logic [3:0] P_SPEC_MODE = 4'h2;
  localparam logic [3:0] P_CFG_FIFO = 4'h2;
  localparam logic [1:0] RES_LEN = 2'h2;

  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_CMD_PROC = 3'h1,
    ST_EXEC = 3'h3,
    ST_RESULT = 3'h2
  } phase_e;
endpackage : fdc_flow_pkg

//--- test/host_bus_model.sv
// host processor model driving the register port of the phase and fifo control block
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // clock
  input wire logic clk_sys,
  // avalon-mm master
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // ----------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // request held until waitrequest samples low, no fixed latency assumed
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= {24'h0, ~d};
  endtask : xfer
  // command bytes go in only while the device asks for them
  task automatic cmd_byte(input logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    while (s[7:6] !== 2'b10) xfer(1'b0, fdc_flow_pkg::ADR_MSR, 8'h00, s);
    xfer(1'b1, fdc_flow_pkg::ADR_DATA, d, s);
  endtask : cmd_byte
endmodule : host_bus_model
`default_nettype wire

//--- test/test_floppy_phase_fifo_control.sv
// self-checking bench for the floppy phase and fifo control block
`timescale 1ns/1ps
`default_nettype none
module test_floppy_phase_fifo_control;
  logic clk_sys, rst, wp, t0, ids, mfound, mdel, crc, miss, ddone, push_v, pop_r;
  logic wait_rq, irq, burst, dens, hd, exec, poll, pdown, push_r, pop_v, rd_s, wr_s;
  logic [7:0] push_d, pop_d, idt, s;
  logic [4:0] adr;
  logic [31:0] wdat, rdat;
  logic [1:0] ds;
  logic dmar;
  int mismatches, n_compared;
  fdc_flow_ctrl i_fdc_flow_ctrl (.clk_sys(clk_sys), .rst(rst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .write_protect_input(wp), .track_zero_input(t0),
    .head_select_output(hd), .drive_select_bits(ds), .density_select_output(dens),
    .cur_track(8'h03), .id_seen(ids), .id_track(idt), .mark_found(mfound),
    .mark_deleted(mdel), .data_crc_err(crc), .mark_missing(miss), .disk_done(ddone),
    .disk_push_valid(push_v), .disk_push_data(push_d), .disk_push_ready(push_r),
    .disk_pop_valid(pop_v), .disk_pop_data(pop_d), .disk_pop_ready(pop_r), .irq(irq),
    .dma_req(dmar), .dma_burst(burst), .exec_active(exec), .exec_read(),
    .polling_active(poll), .powered_down(pdown));
  host_bus_model i_host_bus_model (.clk_sys(clk_sys), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_rq));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host_bus_model.xfer(1'b1, a, d, s);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    i_host_bus_model.xfer(1'b0, a, 8'h00, s);
  endtask : rd
  task automatic msr;
    rd(fdc_flow_pkg::ADR_MSR);
  endtask : msr
  task automatic cmd(input logic [4:0] op, input logic [7:0] p, input logic [3:0] n);
    i_host_bus_model.cmd_byte({3'h0, op});
    for (int i = 1; i <= n; i++) i_host_bus_model.cmd_byte(i == 2 ? p : 8'h00);
  endtask : cmd
  // order: id, mark found, crc, missing, done
  task automatic ev(input logic [4:0] m);
    @(posedge clk_sys);
    {ids, mfound, crc, miss, ddone} <= m;
    @(posedge clk_sys);
    {ids, mfound, crc, miss, ddone} <= 5'h00;
  endtask : ev
  task automatic push(input logic [7:0] d);
    @(posedge clk_sys);
    push_v <= 1'b1;
    push_d <= d;
    do @(posedge clk_sys); while (push_r !== 1'b1);
    push_v <= 1'b0;
    push_d <= ~d;
  endtask : push
  task automatic pop(input logic [7:0] d);
    @(posedge clk_sys);
    pop_r <= 1'b1;
    do @(posedge clk_sys); while (pop_v !== 1'b1);
    chk("disk pop data", pop_d, d);
    pop_r <= 1'b0;
  endtask : pop
  task automatic finish(input logic exp_irq, input logic [7:0] exp3);
    ev(5'h01);
    s = 8'h00;
    while ((s & 8'he0) !== 8'hc0) msr;
    chk("irq at result", irq, exp_irq);
    rd(fdc_flow_pkg::ADR_DATA);
    chk("result st3", s, exp3);
    rd(fdc_flow_pkg::ADR_DATA);
    msr;
    chk("status after results", s & 8'hd0, 8'h80);
    chk("irq after results", irq, 1'b0);
  endtask : finish
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    rd(fdc_flow_pkg::ADR_DOR);
    chk("output reg after reset", s, 8'h04);
    msr;
    chk("request in reset", s[7], 1'b0);
    chk("polling in reset", poll, 1'b0);
    wr(fdc_flow_pkg::ADR_DOR, 8'h00);
    msr;
    chk("status idle", s & 8'hd0, 8'h80);
    chk("polling after reset", poll, 1'b1);
    $display("test t_reset done");
  endtask : t_reset
  task automatic t_status;
    wr(fdc_flow_pkg::ADR_ICFG, 8'h04);
    wr(fdc_flow_pkg::ADR_DOR, 8'h12);
    wp <= 1'b1;
    cmd(fdc_flow_pkg::OP_READ, 8'h00, fdc_flow_pkg::N_XFER);
    chk("head select", {hd, ds}, 8'h06);
    push(8'h11);
    @(posedge clk_sys);
    chk("dma request", dmar, 1'b1);
    rd(fdc_flow_pkg::ADR_DATA);
    chk("dma read data", s, 8'h11);
    msr;
    chk("dma request drained", dmar, 1'b0);
    mdel <= 1'b1;
    idt <= 8'hff;
    ev(5'h1e);
    finish(1'b1, 8'h73);
    rd(fdc_flow_pkg::ADR_ST4);
    chk("st4 first", s, 8'h6e);
    wr(fdc_flow_pkg::ADR_DOR, 8'h01);
    wp <= 1'b0;
    t0 <= 1'b1;
    rd(fdc_flow_pkg::ADR_ST4);
    chk("st4 second", s, 8'h39);
    rd(fdc_flow_pkg::ADR_ST3);
    chk("st3 register", s, 8'h73);
    mdel <= 1'b0;
    cmd(fdc_flow_pkg::OP_READ_DEL, 8'h00, fdc_flow_pkg::N_XFER);
    ev(5'h08);
    finish(1'b1, 8'h40);
    $display("test t_status done");
  endtask : t_status
  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 2; r++) begin
        wr(fdc_flow_pkg::ADR_ICFG, {4'h0, m[1:0], r[0], 1'b0});
        wr(fdc_flow_pkg::ADR_RATE, {7'h00, r[0]});
        @(posedge clk_sys);
        chk("density select", dens, (m == 0) == (r == 0));
        chk("burst mode", burst, r[0]);
      end
    end
    $display("test t_modes done");
  endtask : t_modes
  task automatic t_read_fifo;
    wr(fdc_flow_pkg::ADR_ICFG, 8'h08);
    wr(fdc_flow_pkg::ADR_DOR, 8'h08);
    cmd(fdc_flow_pkg::OP_SPECIFY, 8'h01, fdc_flow_pkg::N_SPECIFY);
    cmd(fdc_flow_pkg::OP_CONFIGURE, 8'h03, fdc_flow_pkg::N_CONFIGURE);
    cmd(fdc_flow_pkg::OP_READ, 8'h00, fdc_flow_pkg::N_XFER);
    msr;
    chk("request after last param", s[7], 1'b0);
    for (int i = 0; i < 11; i++) push(8'h20 + i[7:0]);
    msr;
    chk("request below level", s[7], 1'b0);
    push(8'h2b);
    msr;
    chk("request at level", s & 8'he0, 8'he0);
    chk("irq at level", irq, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rd(fdc_flow_pkg::ADR_DATA);
      chk("fifo read data", s, 8'h20 + i[7:0]);
    end
    msr;
    chk("request when empty", s[7], 1'b0);
    chk("irq when empty", irq, 1'b0);
    finish(1'b1, 8'h00);
    $display("test t_read_fifo done");
  endtask : t_read_fifo
  task automatic t_write_fifo;
    wr(fdc_flow_pkg::ADR_ICFG, 8'h00);
    wr(fdc_flow_pkg::ADR_DOR, 8'h00);
    cmd(fdc_flow_pkg::OP_WRITE, 8'h00, fdc_flow_pkg::N_XFER);
    msr;
    chk("request on entry", s & 8'he0, 8'ha0);
    chk("irq gated off", irq, 1'b0);
    for (int i = 0; i < 16; i++) wr(fdc_flow_pkg::ADR_DATA, 8'h40 + i[7:0]);
    msr;
    chk("request when full", s[7], 1'b0);
    for (int i = 0; i < 11; i++) pop(8'h40 + i[7:0]);
    msr;
    chk("request above threshold", s[7], 1'b0);
    pop(8'h4b);
    msr;
    chk("request at threshold", s[7], 1'b1);
    for (int i = 12; i < 16; i++) pop(8'h40 + i[7:0]);
    finish(1'b0, 8'h00);
    $display("test t_write_fifo done");
  endtask : t_write_fifo
  task automatic t_soft_reset;
    wr(fdc_flow_pkg::ADR_RATE, 8'h40);
    rd(fdc_flow_pkg::ADR_RATE);
    chk("power down set", pdown, 1'b1);
    wr(fdc_flow_pkg::ADR_RATE, 8'hc0);
    msr;
    chk("rate reset self clears", s & 8'hd0, 8'h80);
    chk("rate reset wakes", pdown, 1'b0);
    wr(fdc_flow_pkg::ADR_DOR, 8'h04);
    wr(fdc_flow_pkg::ADR_RATE, 8'h40);
    msr;
    chk("output reg reset held", s[7], 1'b0);
    chk("output reg reset wakes", pdown, 1'b0);
    wr(fdc_flow_pkg::ADR_DOR, 8'h00);
    msr;
    chk("ready after soft reset", s & 8'hd0, 8'h80);
    $display("test t_soft_reset done");
  endtask : t_soft_reset
  task automatic t_hard_reset;
    cmd(fdc_flow_pkg::OP_READ, 8'h00, fdc_flow_pkg::N_XFER);
    push(8'h55);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk("exec aborted", exec, 1'b0);
    rd(fdc_flow_pkg::ADR_DOR);
    chk("reset bit set", s, 8'h04);
    wr(fdc_flow_pkg::ADR_DOR, 8'h00);
    cmd(fdc_flow_pkg::OP_READ, 8'h00, fdc_flow_pkg::N_XFER);
    msr;
    chk("non-dma kept", s & 8'ha0, 8'h20);
    push(8'h66);
    msr;
    chk("fifo back to one byte", s[7], 1'b1);
    rd(fdc_flow_pkg::ADR_DATA);
    chk("single byte read", s, 8'h66);
    finish(1'b0, 8'h00);
    $display("test t_hard_reset done");
  endtask : t_hard_reset
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // generous: the whole sequence needs under a thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    report_and_stop;
  end
  initial begin
    {rst, wp, t0, ids, mfound, mdel, crc, miss, ddone, push_v, pop_r} = 11'h400;
    push_d = 8'h00;
    idt = 8'h00;
    s = 8'h00;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_status;
    t_modes;
    t_read_fifo;
    t_write_fifo;
    t_soft_reset;
    t_hard_reset;
    report_and_stop;
  end
endmodule : test_floppy_phase_fifo_control
`default_nettype wire

//--- verilog/fdc_flow_ctrl.sv
// command, execution and result phase control with fifo flow control
`timescale 1ns/1ps
`default_nettype none
module fdc_flow_ctrl (
  // clock and hardware reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // drive pins
  input wire logic write_protect_input,
  input wire logic track_zero_input,
  output logic head_select_output,
  output logic [1:0] drive_select_bits,
  output logic density_select_output,
  // disk engine status events
  input wire logic [7:0] cur_track,
  input wire logic id_seen,
  input wire logic [7:0] id_track,
  input wire logic mark_found,
  input wire logic mark_deleted,
  input wire logic data_crc_err,
  input wire logic mark_missing,
  input wire logic disk_done,
  // disk side of the fifo
  input wire logic disk_push_valid,
  input wire logic [7:0] disk_push_data,
  output logic disk_push_ready,
  output logic disk_pop_valid,
  output logic [7:0] disk_pop_data,
  input wire logic disk_pop_ready,
  // system outputs
  output logic irq,
  output logic dma_req,
  output logic dma_burst,
  output logic exec_active,
  output logic exec_read,
  output logic polling_active,
  output logic powered_down
);
  typedef struct packed {
    fdc_flow_pkg::phase_e phase;
    logic ack;
    logic [7:0] rdata;
    logic [4:0] digital_output_register;
    logic [1:0] rate;
    logic pdown;
    logic dsr_rst;
    logic [3:0] icfg;
    logic fifo_en;
    logic [3:0] thr_code;
    logic poll_en;
    logic spec_nondma;
    logic [7:0] cmd_byte;
    logic [4:0] opcode;
    logic [3:0] pcount;
    logic [3:0] pneed;
    logic rd_dir;
    logic del_cmd;
    logic [15:0][7:0] mem;
    logic [3:0] rptr;
    logic [3:0] wptr;
    logic [4:0] cnt;
    logic svc;
    logic done_seen;
    logic res_inv;
    logic [1:0] res_idx;
    logic irq_res;
    logic cm;
    logic dd;
    logic wc;
    logic bc;
    logic md;
  } state_s;

  state_s s_q = '0;
  state_s s_d;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [3:0] param_count(input logic [4:0] op);
    unique case (op)
      fdc_flow_pkg::OP_SPECIFY: param_count = fdc_flow_pkg::N_SPECIFY;
      fdc_flow_pkg::OP_CONFIGURE: param_count = fdc_flow_pkg::N_CONFIGURE;
      fdc_flow_pkg::OP_READ, fdc_flow_pkg::OP_READ_DEL,
      fdc_flow_pkg::OP_WRITE: param_count = fdc_flow_pkg::N_XFER;
      default: param_count = 4'h0;
    endcase
  endfunction : param_count

  // threshold in bytes; a disabled fifo behaves as one byte deep
  function automatic logic [4:0] thr_bytes(input logic en, input logic [3:0] code);
    thr_bytes = en ? {1'b0, code} + 5'h01 : 5'h01;
  endfunction : thr_bytes

  function automatic logic [4:0] depth(input logic en);
    depth = en ? fdc_flow_pkg::FIFO_DEPTH : 5'h01;
  endfunction : depth

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic core_rst, acc, do_wr, do_rd, gate, dens_hi, nondma_exec;
  logic request_for_host, transfer_direction_bit, busy, full, empty, host_push, host_pop, dpush, dpop;
  logic [7:0] st3, st4, msr, res_byte;
  logic [4:0] thr, cnt_n;

  assign core_rst = s_q.digital_output_register[fdc_flow_pkg::DOR_RST_BIT] | s_q.dsr_rst;
  assign acc = (avs_read | avs_write) & ~s_q.ack;
  assign do_wr = avs_write & s_q.ack;
  assign do_rd = avs_read & s_q.ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = {24'h0, s_q.rdata};

  assign gate = (s_q.icfg[3:2] == fdc_flow_pkg::IFM_ALWAYS) ? 1'b1
              : s_q.digital_output_register[fdc_flow_pkg::DOR_DMA_BIT];
  assign dens_hi = (s_q.rate == fdc_flow_pkg::RATE_HIGH_DENS);
  assign thr = thr_bytes(s_q.fifo_en, s_q.thr_code);
  assign full = (s_q.cnt >= depth(s_q.fifo_en));
  assign empty = (s_q.cnt == 5'h00);
  assign nondma_exec = (s_q.phase == fdc_flow_pkg::ST_EXEC) & s_q.spec_nondma;

  always_comb begin
    unique case (s_q.phase)
      fdc_flow_pkg::ST_CMD: request_for_host = ~core_rst;
      fdc_flow_pkg::ST_CMD_PROC: request_for_host = 1'b0;
      fdc_flow_pkg::ST_EXEC: request_for_host = s_q.spec_nondma & s_q.svc;
      fdc_flow_pkg::ST_RESULT: request_for_host = 1'b1;
      default: request_for_host = 1'b0;
    endcase
  end
  assign transfer_direction_bit = (s_q.phase == fdc_flow_pkg::ST_RESULT) |
               ((s_q.phase == fdc_flow_pkg::ST_EXEC) & s_q.rd_dir);
  assign busy = (s_q.phase != fdc_flow_pkg::ST_CMD) | (s_q.pcount != 4'h0);
  assign msr = {request_for_host, transfer_direction_bit, nondma_exec, busy, 4'h0};
  assign st3 = {1'b0, s_q.cm, s_q.dd, s_q.wc, 2'b00, s_q.bc, s_q.md};
  assign st4 = {1'b0, write_protect_input, 1'b1, track_zero_input, 1'b1,
                s_q.digital_output_register[fdc_flow_pkg::DOR_HEAD_BIT], s_q.digital_output_register[1:0]};
  assign res_byte = s_q.res_inv ? fdc_flow_pkg::RES_INVALID
                  : (s_q.res_idx == 2'h0) ? st3 : st4;

  // fifo movement; only one direction is live per command
  assign disk_push_ready = nondma_or_dma_rd() & ~full;
  assign disk_pop_valid = (s_q.phase == fdc_flow_pkg::ST_EXEC) & ~s_q.rd_dir & ~empty;
  assign disk_pop_data = s_q.mem[s_q.rptr];
  assign dpush = disk_push_valid & disk_push_ready;
  assign dpop = disk_pop_valid & disk_pop_ready;
  assign host_push = do_wr & (avs_address == fdc_flow_pkg::ADR_DATA) &
                     (s_q.phase == fdc_flow_pkg::ST_EXEC) & ~s_q.rd_dir & ~full;
  assign host_pop = do_rd & (avs_address == fdc_flow_pkg::ADR_DATA) &
                    (s_q.phase == fdc_flow_pkg::ST_EXEC) & s_q.rd_dir & ~empty;
  assign cnt_n = s_q.cnt + {4'h0, dpush | host_push} - {4'h0, dpop | host_pop};

  function automatic logic nondma_or_dma_rd();
    nondma_or_dma_rd = (s_q.phase == fdc_flow_pkg::ST_EXEC) & s_q.rd_dir;
  endfunction : nondma_or_dma_rd

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.dsr_rst = 1'b0;
    // read data is built one edge ahead so it stands at the taking edge
    if (acc) begin
      unique case (avs_address)
        fdc_flow_pkg::ADR_DOR: s_d.rdata = {3'h0, s_q.digital_output_register};
        fdc_flow_pkg::ADR_RATE: s_d.rdata = {1'b0, s_q.pdown, 4'h0, s_q.rate};
        fdc_flow_pkg::ADR_ICFG: s_d.rdata = {4'h0, s_q.icfg};
        fdc_flow_pkg::ADR_MSR: s_d.rdata = msr;
        fdc_flow_pkg::ADR_DATA: s_d.rdata = (s_q.phase == fdc_flow_pkg::ST_RESULT) ?
                                            res_byte : s_q.mem[s_q.rptr];
        fdc_flow_pkg::ADR_ST3: s_d.rdata = st3;
        fdc_flow_pkg::ADR_ST4: s_d.rdata = st4;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // register writes
    if (do_wr) begin
      unique case (avs_address)
        fdc_flow_pkg::ADR_DOR: s_d.digital_output_register = avs_writedata[4:0];
        fdc_flow_pkg::ADR_RATE: begin
          s_d.rate = avs_writedata[1:0];
          s_d.pdown = avs_writedata[fdc_flow_pkg::RATE_PDOWN_BIT];
          s_d.dsr_rst = avs_writedata[fdc_flow_pkg::RATE_RST_BIT];
        end
        fdc_flow_pkg::ADR_ICFG: s_d.icfg = avs_writedata[3:0];
        fdc_flow_pkg::ADR_DATA: begin
          if (s_q.phase == fdc_flow_pkg::ST_CMD && !core_rst) begin
            s_d.cmd_byte = avs_writedata[7:0];
            s_d.phase = fdc_flow_pkg::ST_CMD_PROC;
          end
        end
        default: ;
      endcase
    end
    // command byte processing, one cycle per byte
    if (s_q.phase == fdc_flow_pkg::ST_CMD_PROC) begin
      s_d.phase = fdc_flow_pkg::ST_CMD;
      if (s_q.pcount == 4'h0) begin
        s_d.opcode = s_q.cmd_byte[4:0];
        s_d.pneed = param_count(s_q.cmd_byte[4:0]);
        s_d.del_cmd = (s_q.cmd_byte[4:0] == fdc_flow_pkg::OP_READ_DEL);
        s_d.rd_dir = (s_q.cmd_byte[4:0] != fdc_flow_pkg::OP_WRITE);
        {s_d.cm, s_d.dd, s_d.wc, s_d.bc, s_d.md} = 5'h00;
        if (param_count(s_q.cmd_byte[4:0]) == 4'h0) begin
          s_d.res_inv = 1'b1;
          s_d.res_idx = 2'h0;
          s_d.irq_res = 1'b1;
          s_d.phase = fdc_flow_pkg::ST_RESULT;
        end else begin
          s_d.pcount = 4'h1;
        end
      end else begin
        if (s_q.opcode == fdc_flow_pkg::OP_SPECIFY && s_q.pcount == fdc_flow_pkg::P_SPEC_MODE)
          s_d.spec_nondma = s_q.cmd_byte[fdc_flow_pkg::SPEC_NONDMA_BIT];
        if (s_q.opcode == fdc_flow_pkg::OP_CONFIGURE && s_q.pcount == fdc_flow_pkg::P_CFG_FIFO) begin
          s_d.fifo_en = ~s_q.cmd_byte[fdc_flow_pkg::CFG_NOFIFO_BIT];
          s_d.poll_en = ~s_q.cmd_byte[fdc_flow_pkg::CFG_NOPOLL_BIT];
          s_d.thr_code = s_q.cmd_byte[3:0];
        end
        s_d.pcount = s_q.pcount + 4'h1;
        if (s_q.pcount == s_q.pneed) begin
          s_d.pcount = 4'h0;
          if (s_q.pneed == fdc_flow_pkg::N_XFER) begin
            s_d.phase = fdc_flow_pkg::ST_EXEC;
            s_d.svc = ~s_q.rd_dir;
            s_d.done_seen = 1'b0;
          end
        end
      end
    end
    // execution: fifo and service request
    if (s_q.phase == fdc_flow_pkg::ST_EXEC) begin
      if (dpush | host_push) begin
        s_d.mem[s_q.wptr] = dpush ? disk_push_data : avs_writedata[7:0];
        s_d.wptr = s_q.wptr + 4'h1;
      end
      if (dpop | host_pop)
        s_d.rptr = s_q.rptr + 4'h1;
      s_d.cnt = cnt_n;
      if (disk_done)
        s_d.done_seen = 1'b1;
      if (s_q.rd_dir) begin
        if (cnt_n == 5'h00)
          s_d.svc = 1'b0;
        else if (cnt_n >= depth(s_q.fifo_en) - thr || s_q.done_seen)
          s_d.svc = 1'b1;
      end else begin
        if (cnt_n >= depth(s_q.fifo_en))
          s_d.svc = 1'b0;
        else if (cnt_n <= (s_q.fifo_en ? thr : 5'h00))
          s_d.svc = 1'b1;
      end
      if (s_q.done_seen && empty) begin
        s_d.phase = fdc_flow_pkg::ST_RESULT;
        s_d.svc = 1'b0;
        s_d.res_inv = 1'b0;
        s_d.res_idx = 2'h0;
        s_d.irq_res = 1'b1;
      end
    end else begin
      s_d.rptr = 4'h0;
      s_d.wptr = 4'h0;
      s_d.cnt = 5'h00;
    end
    // result reading
    if (s_q.phase == fdc_flow_pkg::ST_RESULT && do_rd && avs_address == fdc_flow_pkg::ADR_DATA) begin
      s_d.irq_res = 1'b0;
      s_d.res_idx = s_q.res_idx + 2'h1;
      if (s_q.res_inv || s_q.res_idx == fdc_flow_pkg::RES_LEN - 2'h1)
        s_d.phase = fdc_flow_pkg::ST_CMD;
    end
    // status events; applied after the clear so a same-cycle event wins
    if (mark_found && (mark_deleted != s_q.del_cmd))
      s_d.cm = 1'b1;
    if (data_crc_err)
      s_d.dd = 1'b1;
    if (mark_missing)
      s_d.md = 1'b1;
    if (id_seen && id_track != cur_track) begin
      s_d.wc = 1'b1;
      if (id_track == fdc_flow_pkg::BAD_TRACK)
        s_d.bc = 1'b1;
    end
    // soft reset of the core; specify setting survives
    if (core_rst) begin
      s_d.phase = fdc_flow_pkg::ST_CMD;
      s_d.pcount = 4'h0;
      s_d.cnt = 5'h00;
      s_d.rptr = 4'h0;
      s_d.wptr = 4'h0;
      s_d.svc = 1'b0;
      s_d.irq_res = 1'b0;
      s_d.fifo_en = 1'b0;
      s_d.thr_code = 4'h0;
      s_d.poll_en = 1'b1;
      s_d.pdown = 1'b0;
      {s_d.cm, s_d.dd, s_d.wc, s_d.bc, s_d.md} = 5'h00;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // an interrupted disk write is simply abandoned; sector data is left corrupt
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.digital_output_register <= 5'h04;
      s_q.rate <= fdc_flow_pkg::RATE_RST;
      s_q.poll_en <= 1'b1;
      s_q.spec_nondma <= s_q.spec_nondma;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign irq = gate & (s_q.irq_res | (nondma_exec & s_q.svc));
  assign dma_req = gate & ~s_q.spec_nondma & (s_q.phase == fdc_flow_pkg::ST_EXEC) & s_q.svc;
  assign dma_burst = s_q.icfg[fdc_flow_pkg::ICFG_BURST_BIT];
  assign density_select_output = (s_q.icfg[3:2] == fdc_flow_pkg::IFM_COMPAT) ? dens_hi : ~dens_hi;
  assign head_select_output = s_q.digital_output_register[fdc_flow_pkg::DOR_HEAD_BIT];
  assign drive_select_bits = s_q.digital_output_register[1:0];
  assign exec_active = (s_q.phase == fdc_flow_pkg::ST_EXEC);
  assign exec_read = s_q.rd_dir;
  assign polling_active = s_q.poll_en & ~core_rst;
  assign powered_down = s_q.pdown;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_BADTRK: assert property (@(posedge clk_sys) disable iff (rst)
    id_seen && id_track != cur_track && id_track == fdc_flow_pkg::BAD_TRACK && !core_rst
    |=> st3[1] && st3[4]) else $error("bad track flags not set");
  AST_ST4CONST: assert property (@(posedge clk_sys) disable iff (rst)
    st4[5] && st4[3] && !st4[7] && st3[3:2] == 2'b00) else $error("constant status bits wrong");
  AST_HWRST: assert property (@(posedge clk_sys)
    rst |=> s_q.digital_output_register[fdc_flow_pkg::DOR_RST_BIT] && s_q.phase == fdc_flow_pkg::ST_CMD && !irq)
    else $error("hardware reset state wrong");
  AST_DSRCLR: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.dsr_rst |=> !s_q.dsr_rst || do_wr) else $error("rate reset did not self clear");
  AST_RQMDROP: assert property (@(posedge clk_sys) disable iff (rst)
    do_wr && avs_address == fdc_flow_pkg::ADR_DATA && s_q.phase == fdc_flow_pkg::ST_CMD && !core_rst
    |=> !request_for_host ##1 (request_for_host || s_q.phase != fdc_flow_pkg::ST_CMD)) else $error("request not dropped");
  AST_FIFOOFF: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.phase != fdc_flow_pkg::ST_EXEC |=> s_q.cnt == 5'h00 || $past(s_q.phase) != s_q.phase)
    else $error("fifo active outside execution");
  AST_RDREQ: assert property (@(posedge clk_sys) disable iff (rst || core_rst)
    s_q.phase == fdc_flow_pkg::ST_EXEC && s_q.rd_dir && s_q.cnt == 5'h00 |-> !s_q.svc)
    else $error("read request while fifo empty");
  AST_WRFULL: assert property (@(posedge clk_sys) disable iff (rst || core_rst)
    s_q.phase == fdc_flow_pkg::ST_EXEC && !s_q.rd_dir && full |-> !s_q.svc)
    else $error("write request while fifo full");
  AST_MODE2: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.icfg[3:2] == fdc_flow_pkg::IFM_ALWAYS && s_q.irq_res |-> irq) else $error("irq gated in mode two");
  AST_RESEND: assert property (@(posedge clk_sys) disable iff (rst || core_rst)
    s_q.phase == fdc_flow_pkg::ST_RESULT && $past(s_q.phase) == fdc_flow_pkg::ST_RESULT ##0
    s_d.phase == fdc_flow_pkg::ST_CMD |=> request_for_host && !transfer_direction_bit && !busy) else $error("idle status wrong");
endmodule : fdc_flow_ctrl
`default_nettype wire
